// >>> rtl/ore_defines.svh
`ifndef ORE_DEFINES_SVH
`define ORE_DEFINES_SVH

// bus and field widths
`define ORE_DATA_W 8
`define ORE_ADDR_W 8
`define ORE_EVT_W 5

// register offsets
`define ORE_OFS_OTG_CTRL 8'h0A
`define ORE_OFS_OTG_CTRL_SET 8'h0B
`define ORE_OFS_OTG_CTRL_CLR 8'h0C
`define ORE_OFS_RISE 8'h0D
`define ORE_OFS_RISE_SET 8'h0E
`define ORE_OFS_RISE_CLR 8'h0F
`define ORE_OFS_EVT_STATUS 8'h40
`define ORE_OFS_EVT_MASK 8'h41
`define ORE_OFS_LINE_LEVEL 8'h42

// event bit positions, shared by enable, status, mask and level
`define ORE_BIT_HOST_DISC 0
`define ORE_BIT_BUS_PWR 1
`define ORE_BIT_SESS_VALID 2
`define ORE_BIT_SESS_END 3
`define ORE_BIT_ID_GND 4

// control register bit positions
`define ORE_BIT_ID_PULLUP 0
`define ORE_BIT_DPLUS_PD 1
`define ORE_BIT_DMINUS_PD 2

// reset values and implemented-bit masks
`define ORE_RST_RISE 8'h1F
`define ORE_RST_OTG_CTRL 8'h06
`define ORE_RST_EVT_STATUS 5'h00
`define ORE_RST_EVT_MASK 5'h00
`define ORE_RISE_IMPL 8'h1F
`define ORE_OTG_IMPL 8'hFF
`define ORE_READ_IDLE 8'h00

// timing
`define ORE_CLK_HZ 20000000
`define ORE_ID_SETTLE_MS 50
`define ORE_ID_SETTLE_CYCLES (`ORE_ID_SETTLE_MS * (`ORE_CLK_HZ / 1000))

`endif

// >>> rtl/ore_pkg.sv
`include "ore_defines.svh"

package ore_pkg;

    // watched line status, bit 4 down to bit 0
    typedef struct packed {
        logic id_grounded;
        logic session_end;
        logic session_valid;
        logic bus_power_valid;
        logic host_disconnect;
    } ore_line_status_t;

    // one register bus request
    typedef struct packed {
        logic [`ORE_ADDR_W-1:0] addr;
        logic [`ORE_DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } ore_bus_req_t;

    typedef enum logic [1:0] {
        ORE_WM_NONE,
        ORE_WM_PLAIN,
        ORE_WM_SET,
        ORE_WM_CLEAR
    } ore_wmode_t;

    typedef enum logic [1:0] {
        ORE_ST_OFF,
        ORE_ST_SETTLING,
        ORE_ST_READY
    } ore_settle_state_t;

    // register at base, set alias at base+1, clear alias at base+2
    function automatic ore_wmode_t ore_decode_wmode(
        input logic [`ORE_ADDR_W-1:0] addr,
        input logic [`ORE_ADDR_W-1:0] base
    );
        ore_wmode_t m;
        m = ORE_WM_NONE;
        if (addr == base) begin
            m = ORE_WM_PLAIN;
        end else if (addr == `ORE_ADDR_W'(base + 8'h01)) begin
            m = ORE_WM_SET;
        end else if (addr == `ORE_ADDR_W'(base + 8'h02)) begin
            m = ORE_WM_CLEAR;
        end
        return m;
    endfunction

    // next value of a register reached through plain, set or clear
    function automatic logic [`ORE_DATA_W-1:0] ore_apply_write(
        input logic [`ORE_DATA_W-1:0] cur,
        input logic [`ORE_DATA_W-1:0] wdata,
        input ore_wmode_t mode,
        input logic [`ORE_DATA_W-1:0] impl
    );
        logic [`ORE_DATA_W-1:0] n;
        n = cur;
        case (mode)
            ORE_WM_PLAIN: n = wdata;
            ORE_WM_SET: n = cur | wdata;
            ORE_WM_CLEAR: n = cur & ~wdata;
            default: n = cur;
        endcase
        return n & impl;
    endfunction

endpackage

// >>> rtl/ore_edge_detect.sv
`timescale 1ns/10ps

module ore_edge_detect #(
    parameter int unsigned W = 5
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [W-1:0] level_in,
    output logic [W-1:0] rise_out
);

    logic [W-1:0] prev_q;
    logic primed_q;

    ////////////////////////////////////////////////////////////////////////
    // previous level; first sample after reset only primes, so a level
    // already high at reset does not count as a rise
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            prev_q <= '0;
            primed_q <= 1'b0;
        end else if (ce_in) begin
            prev_q <= level_in;
            primed_q <= 1'b1;
        end
    end

    // low-to-high change seen this cycle
    assign rise_out = primed_q ? (level_in & ~prev_q) : '0;

endmodule // ore_edge_detect

// >>> rtl/ore_settle_timer.sv
`timescale 1ns/10ps

module ore_settle_timer
    import ore_pkg::*;
#(
    parameter int unsigned CYCLES = 1000000
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic enable_in,
    output logic ready_out
);

    localparam int unsigned CNT_W = $clog2(CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);

    ore_settle_state_t state_q;
    ore_settle_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    ////////////////////////////////////////////////////////////////////////
    // dropping the enable restarts the whole wait
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ORE_ST_OFF: begin
                cnt_d = '0;
                if (enable_in) begin
                    state_d = ORE_ST_SETTLING;
                end
            end
            ORE_ST_SETTLING: begin
                if (!enable_in) begin
                    state_d = ORE_ST_OFF;
                end else if (cnt_q == CNT_LAST) begin
                    state_d = ORE_ST_READY;
                end else begin
                    cnt_d = CNT_W'(cnt_q + 1'b1);
                end
            end
            ORE_ST_READY: begin
                if (!enable_in) begin
                    state_d = ORE_ST_OFF;
                end
            end
            default: state_d = ORE_ST_OFF;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q <= ORE_ST_OFF;
            cnt_q <= '0;
        end else if (ce_in) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    assign ready_out = (state_q == ORE_ST_READY);

endmodule // ore_settle_timer

// >>> rtl/ore_rise_event_enable.sv
// Operation
// [R1] A rising edge of a watched status signal raises an event when its enable bit is 1, and all five enables reset to 1.
// [R2] Enable bit 4 governs events on a rise of the ID grounded signal.
// [R3] ID grounded rises are dropped while the ID pull-up enable is 0 and for 50 ms after it goes to 1; the code passes them for one cycle after it falls.
// [R4] Enable bit 3 governs events on a rise of the session end signal.
// [R5] Enable bit 2 governs events on a rise of session valid, which is the A-valid indication.
// [R6] Enable bit 1 governs events on a rise of the bus power valid signal.
// [R7] Enable bit 0 governs events on a rise of the host disconnect signal.
// [R8] Host disconnect rises count only in host mode, with both D+ and D- pull-downs enabled.
// [R9] A write to offset 0x0E sets each enable bit written 1, and a read there returns the enables.
// [R10] A write to offset 0x0F clears each enable bit written 1, and a read there returns the enables.
// [R11] The set and clear aliases hold nothing and act only on the enable register at 0x0D.
// [R12] Enable bits 7 to 5 read as 0 through every alias and ignore writes.
// [R13] Bit 0 of the OTG control register enables the ID pull-up and ID sampling.
// [R14] Bits 2 and 1 of the OTG control register are the D- and D+ pull-down enables and reset to 1.
`timescale 1ns/10ps
`include "ore_defines.svh"

module ore_rise_event_enable
    import ore_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = `ORE_ID_SETTLE_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire ore_bus_req_t bus_in,
    output logic [`ORE_DATA_W-1:0] rdata_out,
    input wire ore_line_status_t line_status_in,
    output ore_line_status_t event_out,
    output logic irq_out,
    output logic [`ORE_DATA_W-1:0] otg_ctrl_out,
    output logic id_line_pullup_enable_out,
    output logic dplus_pulldown_enable_out,
    output logic dminus_pulldown_enable_out,
    output logic id_sampling_ready_out
);

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [`ORE_DATA_W-1:0] rise_en_q;
    logic [`ORE_DATA_W-1:0] rise_en_d;
    logic [`ORE_DATA_W-1:0] otg_ctrl_q;
    logic [`ORE_DATA_W-1:0] otg_ctrl_d;
    logic [`ORE_EVT_W-1:0] evt_status_q;
    logic [`ORE_EVT_W-1:0] evt_status_d;
    logic [`ORE_EVT_W-1:0] evt_mask_q;
    logic [`ORE_EVT_W-1:0] evt_mask_d;
    logic [`ORE_EVT_W-1:0] event_q;
    logic [`ORE_DATA_W-1:0] rdata_q;
    logic [`ORE_DATA_W-1:0] rdata_d;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    wire logic wr_go = bus_in.wr & ce_in;
    wire logic rd_go = bus_in.rd & ce_in;

    // three addresses, one register behind them
    wire ore_wmode_t rise_mode = ore_decode_wmode(bus_in.addr,
                                                  `ORE_OFS_RISE); // [R11]
    wire ore_wmode_t otg_mode = ore_decode_wmode(bus_in.addr,
                                                 `ORE_OFS_OTG_CTRL);

    wire logic hit_rise = (rise_mode != ORE_WM_NONE);
    wire logic hit_otg = (otg_mode != ORE_WM_NONE);
    wire logic hit_status = (bus_in.addr == `ORE_OFS_EVT_STATUS);
    wire logic hit_mask = (bus_in.addr == `ORE_OFS_EVT_MASK);
    wire logic hit_level = (bus_in.addr == `ORE_OFS_LINE_LEVEL);

    wire ore_wmode_t rise_wmode = wr_go ? rise_mode : ORE_WM_NONE;
    wire ore_wmode_t otg_wmode = wr_go ? otg_mode : ORE_WM_NONE;
    wire logic wr_status = wr_go & hit_status;
    wire logic wr_mask = wr_go & hit_mask;

    ////////////////////////////////////////////////////////////////////////
    // rise enable register, plain / set / clear access

    // set alias ors in ones, clear alias removes them
    assign rise_en_d = ore_apply_write(rise_en_q, bus_in.wdata, rise_wmode,
                                       `ORE_RISE_IMPL); // [R9] [R10] [R12]

    // every rise enabled out of reset
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rise_en_q <= `ORE_RST_RISE; // [R1]
        end else if (ce_in) begin
            rise_en_q <= rise_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // otg control register, same three-alias scheme

    assign otg_ctrl_d = ore_apply_write(otg_ctrl_q, bus_in.wdata, otg_wmode,
                                        `ORE_OTG_IMPL);

    // pull-downs connected from reset, pull-up off
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            otg_ctrl_q <= `ORE_RST_OTG_CTRL; // [R14]
        end else if (ce_in) begin
            otg_ctrl_q <= otg_ctrl_d;
        end
    end

    // control outputs straight from the register
    assign id_line_pullup_enable_out =
        otg_ctrl_q[`ORE_BIT_ID_PULLUP]; // [R13]
    assign dplus_pulldown_enable_out =
        otg_ctrl_q[`ORE_BIT_DPLUS_PD]; // [R14]
    assign dminus_pulldown_enable_out =
        otg_ctrl_q[`ORE_BIT_DMINUS_PD]; // [R14]
    assign otg_ctrl_out = otg_ctrl_q;

    // host mode needs both line pull-downs
    wire logic host_mode = otg_ctrl_q[`ORE_BIT_DPLUS_PD] &
                           otg_ctrl_q[`ORE_BIT_DMINUS_PD]; // [R8]

    ////////////////////////////////////////////////////////////////////////
    // id settle wait after the pull-up is switched on

    wire logic id_ready;

    // long wait; parameter lets simulation shorten it
    ore_settle_timer #(
        .CYCLES(SETTLE_CYCLES)
    ) u_id_settle (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .enable_in(otg_ctrl_q[`ORE_BIT_ID_PULLUP]), // [R3] [R13]
        .ready_out(id_ready)
    );

    assign id_sampling_ready_out = id_ready;

    ////////////////////////////////////////////////////////////////////////
    // edge detection on the watched lines

    wire logic [`ORE_EVT_W-1:0] line_level = line_status_in;
    wire logic [`ORE_EVT_W-1:0] line_rise;

    ore_edge_detect #(
        .W(`ORE_EVT_W)
    ) u_rise (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .level_in(line_level),
        .rise_out(line_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // per-bit qualification of each rise

    wire logic [`ORE_EVT_W-1:0] rise_gate;

    // id rise dropped while the settle timer is off or still settling; it goes off a cycle after the pull-up
    assign rise_gate[`ORE_BIT_ID_GND] =
        rise_en_q[`ORE_BIT_ID_GND] & id_ready; // [R2] [R3]
    assign rise_gate[`ORE_BIT_SESS_END] =
        rise_en_q[`ORE_BIT_SESS_END]; // [R4]
    assign rise_gate[`ORE_BIT_SESS_VALID] =
        rise_en_q[`ORE_BIT_SESS_VALID]; // [R5]
    assign rise_gate[`ORE_BIT_BUS_PWR] =
        rise_en_q[`ORE_BIT_BUS_PWR]; // [R6]
    // disconnect only means something when we are the host
    assign rise_gate[`ORE_BIT_HOST_DISC] =
        rise_en_q[`ORE_BIT_HOST_DISC] & host_mode; // [R7] [R8]

    // a rise that passes its gate becomes an event
    wire logic [`ORE_EVT_W-1:0] evt_hit = line_rise & rise_gate; // [R1]

    ////////////////////////////////////////////////////////////////////////
    // event pulse towards the delivery path

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            event_q <= '0;
        end else if (ce_in) begin
            event_q <= evt_hit; // [R1]
        end
    end

    assign event_out = event_q;

    ////////////////////////////////////////////////////////////////////////
    // sticky status and mask, interrupt output

    // write one to clear; a new event in the same cycle wins
    wire logic [`ORE_EVT_W-1:0] status_clr =
        wr_status ? bus_in.wdata[`ORE_EVT_W-1:0] : '0;

    assign evt_status_d = (evt_status_q & ~status_clr) | evt_hit;
    assign evt_mask_d = wr_mask ? bus_in.wdata[`ORE_EVT_W-1:0] : evt_mask_q;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            evt_status_q <= `ORE_RST_EVT_STATUS;
            evt_mask_q <= `ORE_RST_EVT_MASK;
        end else if (ce_in) begin
            evt_status_q <= evt_status_d;
            evt_mask_q <= evt_mask_d;
        end
    end

    // level output, stays up until software clears the bit
    assign irq_out = |(evt_status_q & evt_mask_q);

    ////////////////////////////////////////////////////////////////////////
    // read path, data one cycle after the strobe

    wire logic [`ORE_DATA_W-1:0] rd_rise =
        rise_en_q & `ORE_RISE_IMPL; // [R9] [R10] [R12]
    wire logic [`ORE_DATA_W-1:0] rd_status =
        {{(`ORE_DATA_W-`ORE_EVT_W){1'b0}}, evt_status_q};
    wire logic [`ORE_DATA_W-1:0] rd_mask =
        {{(`ORE_DATA_W-`ORE_EVT_W){1'b0}}, evt_mask_q};
    wire logic [`ORE_DATA_W-1:0] rd_level =
        {{(`ORE_DATA_W-`ORE_EVT_W){1'b0}}, line_level};

    // unmapped addresses read as zero; all aliases read the same store
    wire logic [`ORE_DATA_W-1:0] rd_value =
        hit_rise ? rd_rise :
        hit_otg ? otg_ctrl_q :
        hit_status ? rd_status :
        hit_mask ? rd_mask :
        hit_level ? rd_level :
        `ORE_READ_IDLE; // [R11]

    // data only in the cycle right after the strobe
    assign rdata_d = rd_go ? rd_value : `ORE_READ_IDLE;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_q <= `ORE_READ_IDLE;
        end else if (ce_in) begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;

endmodule // ore_rise_event_enable

// >>> sim/ore_rise_monitor.sv
`timescale 1ns/10ps
`include "ore_defines.svh"

module ore_rise_monitor
    import ore_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = 8
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire ore_bus_req_t bus_in,
    input wire logic [`ORE_DATA_W-1:0] rdata_out,
    input wire ore_line_status_t line_status_in,
    input wire ore_line_status_t event_out,
    input wire logic irq_out,
    input wire logic [`ORE_DATA_W-1:0] otg_ctrl_out,
    input wire logic id_line_pullup_enable_out,
    input wire logic dplus_pulldown_enable_out,
    input wire logic dminus_pulldown_enable_out,
    input wire logic id_sampling_ready_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    int unsigned up_cnt_q;

    ////////////////////////////////////////////////////////////////////////
    // cycles the pull-up has been on; assumes the clock enable stays high
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !id_line_pullup_enable_out) begin
            up_cnt_q <= 0;
        end else if (up_cnt_q < SETTLE_CYCLES + 4) begin
            up_cnt_q <= up_cnt_q + 1;
        end
    end

    // accesses to the enable register or one of its aliases
    sequence rd_en_s;
        ce_in && bus_in.rd && bus_in.addr inside {8'h0D, 8'h0E, 8'h0F};
    endsequence
    sequence wr_at_s(logic [7:0] a);
        ce_in && bus_in.wr && bus_in.addr == a;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    evt_from_rise_a: assert property (
        $past(ce_in) && $past(ce_in, 2) |-> (event_out &
        ~($past(line_status_in) & ~$past(line_status_in, 2))) == 5'h00
    ) else $error("event without a rising line");
    evt_pulse_a: assert property (
        $past(ce_in) |-> (event_out & $past(event_out)) == 5'h00
    ) else $error("event longer than one cycle");
    host_mode_a: assert property (
        event_out.host_disconnect |->
        $past(dplus_pulldown_enable_out) && $past(dminus_pulldown_enable_out)
    ) else $error("disconnect event outside host mode");
    id_gate_a: assert property (
        event_out.id_grounded |->
        $past(id_line_pullup_enable_out) && $past(id_sampling_ready_out)
    ) else $error("id event while suppressed");
    settle_early_a: assert property (
        up_cnt_q < SETTLE_CYCLES |-> !id_sampling_ready_out
    ) else $error("id sampling ready too early");
    settle_late_a: assert property (
        up_cnt_q >= SETTLE_CYCLES + 3 |-> id_sampling_ready_out
    ) else $error("id sampling ready too late");
    ctrl_pins_a: assert property (
        {dminus_pulldown_enable_out, dplus_pulldown_enable_out,
        id_line_pullup_enable_out} == otg_ctrl_out[2:0]
    ) else $error("control pins differ from register");
    ctrl_reset_a: assert property (
        $fell(rst_in) |-> otg_ctrl_out == 8'h06
    ) else $error("control register reset value");
    rd_idle_a: assert property (
        $past(ce_in) && !$past(bus_in.rd) |-> rdata_out == 8'h00
    ) else $error("read data without a read");
    rsvd_zero_a: assert property (
        rd_en_s |=> rdata_out[7:5] == 3'h0
    ) else $error("reserved enable bits not zero");
    alias_same_a: assert property (
        rd_en_s ##1 rd_en_s |=> rdata_out == $past(rdata_out)
    ) else $error("aliases read differently");
    set_alias_a: assert property (
        wr_at_s(8'h0E) ##1 rd_en_s |=> (rdata_out & $past(bus_in.wdata, 2)
        & 8'h1F) == ($past(bus_in.wdata, 2) & 8'h1F)
    ) else $error("set alias left a bit clear");
    clear_alias_a: assert property (
        wr_at_s(8'h0F) ##1 rd_en_s |=>
        (rdata_out & $past(bus_in.wdata, 2)) == 8'h00
    ) else $error("clear alias left a bit set");
endmodule // ore_rise_monitor

bind ore_rise_event_enable ore_rise_monitor #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) ore_rise_monitor_i (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .bus_in(bus_in), .rdata_out(rdata_out),
    .line_status_in(line_status_in), .event_out(event_out),
    .irq_out(irq_out), .otg_ctrl_out(otg_ctrl_out),
    .id_line_pullup_enable_out(id_line_pullup_enable_out),
    .dplus_pulldown_enable_out(dplus_pulldown_enable_out),
    .dminus_pulldown_enable_out(dminus_pulldown_enable_out),
    .id_sampling_ready_out(id_sampling_ready_out)
);

// >>> sim/ore_link_model.sv
`timescale 1ns/10ps
`include "ore_defines.svh"

module ore_link_model
    import ore_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic [`ORE_DATA_W-1:0] rdata_in,
    output ore_bus_req_t bus_out
);
    initial bus_out = '0;

    ////////////////////////////////////////////////////////////////////////
    // one access, then a read right behind it; returns the read's data
    // mid-cycle, away from the edge that replaces it with zero
    task automatic acc2(input logic w, input logic [7:0] a1, d1, a2,
                        output logic [7:0] r);
        @(posedge ref_clk_in) bus_out <= '{a1, d1, w, !w};
        @(posedge ref_clk_in) bus_out <= '{a2, 8'h00, 1'b0, 1'b1};
        // idle fields change so unstrobed use of them shows up
        @(posedge ref_clk_in) bus_out <= '{~a2, ~d1, 1'b0, 1'b0};
        @(negedge ref_clk_in) r = rdata_in;
    endtask
endmodule // ore_link_model

// >>> sim/tb_top.sv
`timescale 1ns/10ps
`include "ore_defines.svh"

module tb_top
    import ore_pkg::*;
;
    localparam int unsigned SETTLE = 8; // short stand-in for 50 ms

    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic [4:0] line = 5'h00;
    ore_bus_req_t bus;
    ore_line_status_t evt;
    logic [7:0] rdata, q, m, a, b, d;
    logic irq, rdy;
    logic [31:0] seed = 32'h9F3A;
    int fails = 0;
    int n_compared = 0;

    always #25 ref_clk_in = ~ref_clk_in;

    ore_rise_event_enable #(.SETTLE_CYCLES(SETTLE)) ore_rise_event_enable_i (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .bus_in(bus), .rdata_out(rdata), .line_status_in(line),
        .event_out(evt), .irq_out(irq), .otg_ctrl_out(),
        .id_line_pullup_enable_out(), .dplus_pulldown_enable_out(),
        .dminus_pulldown_enable_out(), .id_sampling_ready_out(rdy)
    );
    ore_link_model ore_link_model_i (
        .ref_clk_in(ref_clk_in), .rdata_in(rdata), .bus_out(bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // expectation helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_en(input logic [7:0] cur, a, d);
        case (a)
            8'h0D: return d & 8'h1F;
            8'h0E: return (cur | d) & 8'h1F;
            8'h0F: return cur & ~d & 8'h1F;
            default: return cur;
        endcase
    endfunction

    task automatic cmp_val(input string what, input logic [7:0] e, g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_bit(input string what, input logic e, g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic print_verdict;
        if (fails == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic pair(input logic w, input logic [7:0] a1, d1, a2,
                        output logic [7:0] r);
        ore_link_model_i.acc2(w, a1, d1, a2, r);
    endtask

    // raise one line, check pulse, irq and sticky status, then clear it
    task automatic rise(input int i, input logic x, input logic irq_on);
        @(posedge ref_clk_in) line <= line | 5'(1 << i);
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        cmp_val("event", 8'(x) << i, {3'h0, evt});
        cmp_bit("irq", x & irq_on, irq);
        @(posedge ref_clk_in) line <= 5'h00;
        pair(1'b0, 8'h42, 8'h00, 8'h40, q);
        cmp_val("status", 8'(x) << i, q);
        pair(1'b1, 8'h40, 8'h1F, 8'h40, q);
        cmp_val("status", 8'h00, q);
        cmp_bit("irq", 1'b0, irq);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        pair(1'b0, 8'h0D, 8'h00, 8'h0E, q);
        cmp_val("rise enable", 8'h1F, q);
        pair(1'b0, 8'h0E, 8'h00, 8'h0F, q);
        cmp_val("rise enable", 8'h1F, q);
        pair(1'b0, 8'h0F, 8'h00, 8'h0A, q);
        cmp_val("otg control", 8'h06, q);
        m = 8'h1F;
        // random writes through all three offsets, read back through a random one of them
        for (int k = 0; k < 24; k++) begin
            seed = lfsr(seed);
            a = 8'h0D + 8'(seed[3:0] % 3);
            b = 8'h0D + 8'(seed[7:4] % 3);
            d = seed[15:8];
            m = exp_en(m, a, d);
            pair(1'b1, a, d, b, q);
            cmp_val("rise enable", m, q);
        end
        ce_in <= 1'b0;
        pair(1'b1, 8'h0F, 8'hFF, 8'h0D, q);
        ce_in <= 1'b1;
        pair(1'b1, 8'h13, 8'hFF, 8'h0E, q);
        cmp_val("rise enable", m, q);
        pair(1'b0, 8'h0D, 8'h00, 8'h13, q);
        cmp_val("unmapped", 8'h00, q);
        pair(1'b1, 8'h0F, 8'hFF, 8'h0E, q);
        cmp_val("rise enable", 8'h00, q);
        pair(1'b1, 8'h0E, 8'hFF, 8'h0D, q);
        cmp_val("rise enable", 8'h1F, q);
        // events per line, enabled and disabled
        pair(1'b1, 8'h41, 8'h1F, 8'h41, q);
        cmp_val("mask", 8'h1F, q);
        pair(1'b1, 8'h0B, 8'h01, 8'h0A, q);
        cmp_val("otg control", 8'h07, q);
        rise(4, 1'b0, 1'b1);
        repeat (12) @(posedge ref_clk_in);
        cmp_bit("id ready", 1'b1, rdy);
        for (int i = 0; i < 5; i++) begin
            for (int e = 0; e < 2; e++) begin
                pair(1'b1, 8'h0D, 8'(e) << i, 8'h0D, q);
                rise(i, e[0], 1'b1);
            end
        end
        // host mode needs both pull-downs; id needs the pull-up
        pair(1'b1, 8'h0D, 8'h1F, 8'h0C, q);
        for (int j = 1; j < 3; j++) begin
            pair(1'b1, 8'h0C, 8'(1 << j), 8'h0A, q);
            cmp_val("otg control", 8'h07 ^ 8'(1 << j), q);
            rise(0, 1'b0, 1'b1);
            pair(1'b1, 8'h0B, 8'(1 << j), 8'h0A, q);
        end
        pair(1'b1, 8'h0C, 8'h01, 8'h0A, q);
        cmp_val("otg control", 8'h06, q);
        rise(4, 1'b0, 1'b1);
        pair(1'b1, 8'h41, 8'h00, 8'h41, q);
        rise(1, 1'b1, 1'b0);
        print_verdict;
    end

    // hang guard, far beyond the run of roughly three hundred cycles
    initial begin
        repeat (5000) @(posedge ref_clk_in);
        fails++;
        print_verdict;
    end
endmodule // tb_top
